//--- rtl/seh_host_port.sv
`include "seh_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module seh_host_port (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic                   reset_powerdown_input,
  output logic                        osc_enable,
  output seh_pkg::seh_mode_e          mode,
  input  wire logic                   address_strobe_low,
  input  wire logic                   a2_pin,
  input  wire logic                   a1_pin,
  input  wire logic                   a0_in,
  output logic                        a0_out,
  output logic                        a0_oe_n,
  input  wire logic                   data_strobe_low,
  input  wire logic                   write_low_pin,
  input  wire logic                   chip_select_low,
  input  wire logic [`SEH_DATA_W-1:0] data_in,
  output logic [`SEH_DATA_W-1:0]      data_out,
  output logic                        data_oe_n,
  output logic                        rd_req,
  output logic [`SEH_ADDR_W-1:0]      rd_addr,
  input  wire logic [`SEH_DATA_W-1:0] rd_data,
  output logic                        wr_valid,
  input  wire logic                   wr_ready,
  output logic [`SEH_ADDR_W-1:0]      wr_addr,
  output logic [`SEH_DATA_W-1:0]      wr_data,
  output logic                        wr_overrun
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [`SEH_PIN_N-1:0]  pin_raw;
  logic [`SEH_PIN_N-1:0]  pin_s1_reg;
  logic [`SEH_PIN_N-1:0]  pin_s2_reg;
  logic [`SEH_PIN_N-1:0]  pin_d_reg;
  logic [`SEH_DATA_W-1:0] dat_s1_reg;
  logic [`SEH_DATA_W-1:0] dat_s2_reg;
  logic [1:0]             rpd_s_reg;

  assign pin_raw = {chip_select_low, write_low_pin, data_strobe_low, a0_in,
                    a1_pin, a2_pin, address_strobe_low};

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_s1_reg <= 7'h7f;
      pin_s2_reg <= 7'h7f;
      pin_d_reg  <= 7'h7f;
      dat_s1_reg <= 8'h00;
      dat_s2_reg <= 8'h00;
      rpd_s_reg  <= 2'h3;
    end else begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
      pin_d_reg  <= pin_s2_reg;
      dat_s1_reg <= data_in;
      dat_s2_reg <= dat_s1_reg;
      rpd_s_reg  <= {rpd_s_reg[0], reset_powerdown_input};
    end
  end

  function automatic logic fell(input logic [`SEH_PIN_N-1:0] now,
                                input logic [`SEH_PIN_N-1:0] was, input int idx);
    fell = was[idx] && !now[idx];
  endfunction

  logic rpd;
  assign rpd        = rpd_s_reg[1];
  assign osc_enable = !rpd;

  // ----------------------------------------
  // interface mode detection
  // ----------------------------------------
  seh_pkg::seh_mode_e mode_reg;
  assign mode = mode_reg;

  // high input holds the mode cleared; its fall starts a fresh detection
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_reg <= seh_pkg::SEH_MODE_NONE;
    end else if (rpd) begin
      mode_reg <= seh_pkg::SEH_MODE_NONE;
    end else if (mode_reg == seh_pkg::SEH_MODE_NONE) begin
      if (!pin_s2_reg[`SEH_P_A1] && pin_s2_reg[`SEH_P_RD] && pin_s2_reg[`SEH_P_WR]
          && !pin_s2_reg[`SEH_P_CS]) begin
        mode_reg <= seh_pkg::SEH_MODE_SPI;
      end else if (pin_s2_reg[`SEH_P_A2] && pin_s2_reg[`SEH_P_A1]) begin
        mode_reg <= seh_pkg::SEH_MODE_EPP;
      end else begin
        mode_reg <= seh_pkg::SEH_MODE_PAR;
      end
    end
  end

  // ----------------------------------------
  // serial slave: ale=select, a2=clock, a0=mosi
  // ----------------------------------------
  logic                   spi_act;
  logic                   sck_rise;
  logic                   sck_fall;
  logic [2:0]             bit_cnt_reg;
  logic [7:0]             rx_sh_reg;
  logic [7:0]             tx_sh_reg;
  logic                   first_reg;
  logic                   is_read_reg;
  logic [`SEH_ADDR_W-1:0] wa_reg;
  logic                   byte_done_reg;
  logic [7:0]             byte_reg;
  logic                   rd_pend_reg;

  assign spi_act  = (mode_reg == seh_pkg::SEH_MODE_SPI) && !pin_s2_reg[`SEH_P_ALE];
  assign sck_rise = pin_s2_reg[`SEH_P_A2] && !pin_d_reg[`SEH_P_A2];
  assign sck_fall = fell(pin_s2_reg, pin_d_reg, `SEH_P_A2);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bit_cnt_reg   <= 3'h0;
      rx_sh_reg     <= 8'h00;
      byte_done_reg <= 1'b0;
      byte_reg      <= 8'h00;
    end else begin
      byte_done_reg <= 1'b0;
      if (!spi_act) begin
        bit_cnt_reg <= 3'h0;
      end else if (sck_rise) begin
        rx_sh_reg   <= {rx_sh_reg[6:0], pin_s2_reg[`SEH_P_A0]};
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (bit_cnt_reg == `SEH_BIT_LAST) begin
          byte_done_reg <= 1'b1;
          byte_reg      <= {rx_sh_reg[6:0], pin_s2_reg[`SEH_P_A0]};
        end
      end
    end
  end

  // first byte picks direction and write address; later bytes follow it, reads take each byte's own address
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      first_reg   <= 1'b1;
      is_read_reg <= 1'b0;
      wa_reg      <= 6'h00;
    end else if (!spi_act) begin
      first_reg <= 1'b1;
    end else if (byte_done_reg && first_reg) begin
      first_reg   <= 1'b0;
      is_read_reg <= byte_reg[`SEH_RW_BIT];
      wa_reg      <= byte_reg[`SEH_ADDR_HI:`SEH_ADDR_LO];
    end
  end

  // no shift on the fall after the eighth rise: reload lands there
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_sh_reg <= 8'h00;
    end else if (!spi_act) begin
      tx_sh_reg <= 8'h00;
    end else if (rd_pend_reg) begin
      tx_sh_reg <= rd_data;
    end else if (sck_fall && bit_cnt_reg != 3'h0) begin
      tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
    end
  end

  // ----------------------------------------
  // handshake parallel mode
  // ----------------------------------------
  logic                   epp_mode;
  logic                   ds_act;
  logic                   ds_fall;
  logic                   as_fall;
  logic                   wait_def_reg;
  logic                   wait_reg;
  logic [`SEH_ADDR_W-1:0] epp_addr_reg;
  logic [7:0]             epp_dat_reg;
  logic                   epp_rd_reg;

  assign epp_mode = (mode_reg == seh_pkg::SEH_MODE_EPP);
  // chip select tied low when the gating is unused
  assign ds_act   = !pin_s2_reg[`SEH_P_RD] && !pin_s2_reg[`SEH_P_CS];
  assign ds_fall  = ds_act && (pin_d_reg[`SEH_P_RD] || pin_d_reg[`SEH_P_CS]);
  assign as_fall  = fell(pin_s2_reg, pin_d_reg, `SEH_P_ALE);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wait_def_reg <= 1'b0;
    end else if (rpd || !epp_mode) begin
      wait_def_reg <= 1'b0;
    end else if (as_fall) begin
      wait_def_reg <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wait_reg     <= 1'b0;
      epp_addr_reg <= 6'h00;
      epp_dat_reg  <= 8'h00;
      epp_rd_reg   <= 1'b0;
    end else begin
      wait_reg <= epp_mode && (ds_act || !pin_s2_reg[`SEH_P_ALE]);
      if (epp_mode && as_fall && !pin_s2_reg[`SEH_P_WR]) begin
        epp_addr_reg <= dat_s2_reg[`SEH_ADDR_W-1:0];
      end
      if (epp_mode && ds_fall) begin
        epp_rd_reg <= pin_s2_reg[`SEH_P_WR];
      end else if (!ds_act) begin
        epp_rd_reg <= 1'b0;
      end
      if (rd_pend_reg && epp_mode) begin
        epp_dat_reg <= rd_data;
      end
    end
  end

  assign a0_out  = wait_reg;
  assign a0_oe_n = !(epp_mode && wait_def_reg);

  // ----------------------------------------
  // register read requests and write stream
  // ----------------------------------------
  logic                   push;
  logic [`SEH_FIFO_W-1:0] push_data;
  logic                   push_ready;
  logic                   rd_req_reg;
  logic [`SEH_ADDR_W-1:0] rd_addr_reg;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_req_reg  <= 1'b0;
      rd_addr_reg <= 6'h00;
      rd_pend_reg <= 1'b0;
    end else begin
      rd_pend_reg <= rd_req_reg;
      rd_req_reg  <= 1'b0;
      if (byte_done_reg && (first_reg ? byte_reg[`SEH_RW_BIT] : is_read_reg)) begin
        rd_req_reg  <= 1'b1;
        rd_addr_reg <= byte_reg[`SEH_ADDR_HI:`SEH_ADDR_LO];
      end else if (epp_mode && ds_fall && pin_s2_reg[`SEH_P_WR]) begin
        rd_req_reg  <= 1'b1;
        rd_addr_reg <= epp_addr_reg;
      end
    end
  end

  assign rd_req  = rd_req_reg;
  assign rd_addr = rd_addr_reg;

  // a serial master cannot be stalled: a full buffer drops and flags
  assign push = (byte_done_reg && !first_reg && !is_read_reg)
                || (epp_mode && ds_fall && !pin_s2_reg[`SEH_P_WR]);
  assign push_data = (mode_reg == seh_pkg::SEH_MODE_SPI) ? {wa_reg, byte_reg}
                     : {epp_addr_reg, dat_s2_reg};
  assign wr_overrun = push && !push_ready;

  seh_fifo #(.W(`SEH_FIFO_W), .D(`SEH_FIFO_DEPTH)) u_fifo (
    .clk       (core_clk),
    .rst       (rst),
    .in_valid  (push),
    .in_ready  (push_ready),
    .in_data   (push_data),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  ({wr_addr, wr_data})
  );

  assign data_out  = (mode_reg == seh_pkg::SEH_MODE_SPI) ? {7'h00, tx_sh_reg[7]} : epp_dat_reg;
  assign data_oe_n = !(spi_act || (epp_mode && epp_rd_reg && ds_act));

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // mode clears on the edge after the synced input rises, not in the same cycle
  chk_osc_inhibit: assert property (rpd |-> !osc_enable
                                    ##1 mode_reg == seh_pkg::SEH_MODE_NONE)
    else $error("oscillator or mode active during power-down");
  chk_mode_detect: assert property (!rpd && mode_reg == seh_pkg::SEH_MODE_NONE
                                    ##1 !rpd |-> mode_reg != seh_pkg::SEH_MODE_NONE)
    else $error("mode not detected after reset phase");
  chk_wait_hiz: assert property (!wait_def_reg |-> a0_oe_n)
    else $error("wait pin driven before defined");
  chk_wait_first: assert property (epp_mode && !rpd && as_fall ##1 epp_mode |-> !a0_oe_n)
    else $error("wait not defined after address strobe");
  chk_rd_follow: assert property (byte_done_reg && !first_reg && is_read_reg
                                  |=> rd_req && rd_addr == $past(byte_reg[6:1]))
    else $error("burst read address not requested");
  chk_rd_load: assert property (spi_act && rd_req ##1 spi_act |=> tx_sh_reg == $past(rd_data))
    else $error("read data not loaded for miso");
  chk_wr_fixed: assert property (push && spi_act |-> push_data[13:8] == wa_reg
                                 && !first_reg && !is_read_reg)
    else $error("write burst address moved");
  chk_miso_drive: assert property (spi_act |-> !data_oe_n)
    else $error("miso not driven in frame");
  chk_epp_gate: assert property (epp_mode && pin_s2_reg[`SEH_P_CS] |-> !ds_act)
    else $error("data strobe not gated by chip select");
  chk_no_addr_rd: assert property (epp_mode && as_fall && pin_s2_reg[`SEH_P_WR]
                                   |=> $stable(epp_addr_reg))
    else $error("address read cycle altered address");

  cov_spi_read: cover property (byte_done_reg && !first_reg && is_read_reg);
  cov_spi_write: cover property (push && spi_act);
  cov_epp_write: cover property (epp_mode && push);
  cov_overrun: cover property (wr_overrun);
endmodule // seh_host_port
`default_nettype wire

//--- pkg/seh_cfg.svh
`ifndef SEH_CFG_SVH
`define SEH_CFG_SVH
// ----------------------------------------
// widths and field positions
// ----------------------------------------
`define SEH_ADDR_W     6
`define SEH_DATA_W     8
`define SEH_RW_BIT     7
`define SEH_ADDR_HI    6
`define SEH_ADDR_LO    1
`define SEH_BIT_LAST   3'h7
`define SEH_FIFO_DEPTH 4
`define SEH_FIFO_W     14
// ----------------------------------------
// pin vector positions, sampled bundle
// ----------------------------------------
`define SEH_PIN_N      7
`define SEH_P_ALE      0
`define SEH_P_A2       1
`define SEH_P_A1       2
`define SEH_P_A0       3
`define SEH_P_RD       4
`define SEH_P_WR       5
`define SEH_P_CS       6
`endif

//--- pkg/seh_pkg.sv
package seh_pkg;
  typedef enum logic [1:0] {
    SEH_MODE_NONE = 2'b00,
    SEH_MODE_SPI  = 2'b01,
    SEH_MODE_EPP  = 2'b10,
    SEH_MODE_PAR  = 2'b11
  } seh_mode_e;
endpackage

//--- rtl/seh_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module seh_fifo #(
  parameter int W = 14,
  parameter int D = 4
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0]  mem_reg [D];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0]   count_reg;
  logic          push;
  logic          pop;

  assign in_ready  = (count_reg != (AW+1)'(D));
  assign out_valid = (count_reg != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_reg[rd_ptr_reg];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // pointers wrap by compare, depth need not be a power of two
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(D-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(D-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // seh_fifo
`default_nettype wire

//--- verif/seh_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// host master model: serial and handshake
// ----------------------------------------
module seh_host_model (
  input  wire logic       core_clk,
  input  wire logic       miso_oe_n,
  input  wire logic       miso,
  input  wire logic       wait_in,
  input  wire logic [7:0] bus_in,
  output logic            sel_low,
  output logic            sck,
  output logic            mosi,
  output logic            dstb_low,
  output logic            wr_low,
  output logic            cs_low,
  output logic [7:0]      bus_out,
  output logic            rx_stb,
  output logic [7:0]      rx_byte
);
  logic miso_last;

  task automatic idle(input logic epp);
    sel_low  = 1'b1;
    sck      = epp;
    mosi     = 1'b0;
    dstb_low = 1'b1;
    wr_low   = 1'b1;
    cs_low   = 1'b0;
    bus_out  = 8'h00;
  endtask

  task automatic report(input logic [7:0] b);
    @(negedge core_clk);
    rx_byte = b;
    rx_stb  = 1'b1;
    @(negedge core_clk);
    rx_stb  = 1'b0;
  endtask

  task automatic spi_sel(input logic v);
    @(negedge core_clk);
    sel_low = v;
    #80;
  endtask

  // undriven miso reads as the inverse of its last level
  task automatic spi_byte(input logic [7:0] tx, input logic keep);
    logic [7:0] rx;
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      #40 sck = 1'b1;
      rx[i] = miso_oe_n ? ~miso_last : miso;
      miso_last = rx[i];
      #40 sck = 1'b0;
    end
    #80 mosi = ~mosi;
    if (keep) report(rx);
  endtask

  // address writes, data writes and data reads are issued; reads report the byte
  task automatic epp_cycle(input logic is_addr, input logic is_wr, input logic cs,
                           input logic [7:0] d);
    logic [7:0] rx;
    @(negedge core_clk);
    cs_low  = cs;
    wr_low  = ~is_wr;
    bus_out = d;
    if (is_addr) sel_low = 1'b0;
    else dstb_low = 1'b0;
    for (int n = 0; n < 20 && wait_in !== 1'b1; n++) @(negedge core_clk);
    repeat (4) @(negedge core_clk);
    rx       = bus_in;
    sel_low  = 1'b1;
    dstb_low = 1'b1;
    for (int n = 0; n < 20 && wait_in !== 1'b0; n++) @(negedge core_clk);
    cs_low  = 1'b0;
    wr_low  = 1'b1;
    bus_out = ~d;
    if (!is_wr) report(rx);
  endtask

  initial begin
    miso_last = 1'b0;
    rx_stb    = 1'b0;
    rx_byte   = 8'h00;
    idle(1'b0);
  end
endmodule // seh_host_model
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                     core_clk, rst, rpd, a1, wr_ready, osc_enable;
  logic                     a0_out, a0_oe_n, data_oe_n, rd_req, wr_valid, wr_overrun;
  logic                     sel_low, sck, mosi, dstb_low, wr_low, cs_low, rx_stb, a0_w;
  logic [1:0]               rdy_mode;
  logic [5:0]               rd_addr, wr_addr, a;
  logic [7:0]               mask, rd_data, data_out, wr_data, bus_out, bus_w, rx_byte, d;
  logic [5:0]               ra [4];
  logic [7:0]               stat;
  seh_pkg::seh_mode_e       mode;
  logic [13:0]              exp_wr [$];
  logic [7:0]               exp_rd [$];
  int                       mismatches, check_count, ovr;

  function automatic logic [7:0] fdat(input logic [5:0] x);
    return {x, 2'b01} ^ mask;
  endfunction
  // ----------------------------------------
  // wiring of shared pins
  // ----------------------------------------
  // mask as a direct operand, so a change of it re-evaluates the far side
  assign rd_data = {rd_addr, 2'b01} ^ mask;
  assign stat    = {4'h0, osc_enable, a0_oe_n, mode};
  assign a0_w    = a0_oe_n ? mosi : a0_out;
  assign bus_w   = data_oe_n ? bus_out : data_out;

  seh_host_port u_seh_host_port (.core_clk(core_clk), .rst(rst),
    .reset_powerdown_input(rpd), .osc_enable(osc_enable), .mode(mode),
    .address_strobe_low(sel_low), .a2_pin(sck), .a1_pin(a1), .a0_in(a0_w),
    .a0_out(a0_out), .a0_oe_n(a0_oe_n), .data_strobe_low(dstb_low),
    .write_low_pin(wr_low), .chip_select_low(cs_low), .data_in(bus_w),
    .data_out(data_out), .data_oe_n(data_oe_n), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
    .wr_data(wr_data), .wr_overrun(wr_overrun));

  seh_host_model u_seh_host_model (.core_clk(core_clk), .miso_oe_n(data_oe_n),
    .miso(data_out[0]), .wait_in(a0_w), .bus_in(bus_w), .sel_low(sel_low), .sck(sck),
    .mosi(mosi), .dstb_low(dstb_low), .wr_low(wr_low), .cs_low(cs_low),
    .bus_out(bus_out), .rx_stb(rx_stb), .rx_byte(rx_byte));
  // ----------------------------------------
  // comparison and closing
  // ----------------------------------------
  task automatic chk_wr(input string what, input logic [13:0] exp, input logic [13:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_v(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // clock, far-side ready, result watchers
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // far side stalls, wobbles or accepts
  always @(posedge core_clk)
    wr_ready <= (rdy_mode == 2'd2) || (rdy_mode == 2'd1 && $urandom_range(1));

  always @(posedge core_clk) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1)
      chk_wr("write stream", exp_wr.size() > 0 ? exp_wr.pop_front() : 14'hxxxx,
             {wr_addr, wr_data});
    if (wr_overrun === 1'b1) ovr++;
  end

  always @(posedge core_clk) begin
    if (rx_stb === 1'b1)
      chk_v("read byte", exp_rd.size() > 0 ? exp_rd.pop_front() : 8'hxx, rx_byte);
  end

  initial begin
    #300000;
    mismatches++;
    results();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    rpd = 1'b0;
    a1 = 1'b0;
    rdy_mode = 2'd2;
    mismatches = 0;
    check_count = 0;
    ovr = 0;
    void'($urandom(66));
    mask = 8'($urandom);
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    repeat (8) @(posedge core_clk);
    #1 chk_v("spi status", {6'h03, seh_pkg::SEH_MODE_SPI}, stat);
    for (int b = 0; b < 2; b++) begin
      a = 6'($urandom);
      ovr = 0;
      rdy_mode = 2'(b);
      u_seh_host_model.spi_sel(1'b0);
      u_seh_host_model.spi_byte({1'b0, a, 1'b0}, 1'b0);
      for (int k = 0; k < 6; k++) begin
        d = 8'($urandom);
        if (b == 1 || k < 4) exp_wr.push_back({a, d});
        u_seh_host_model.spi_byte(d, 1'b0);
      end
      u_seh_host_model.spi_sel(1'b1);
      rdy_mode = 2'd2;
      repeat (20) @(posedge core_clk);
      chk_v("overruns", b ? 8'h00 : 8'h02, 8'(ovr));
      chk_v("writes left", 8'h00, 8'(exp_wr.size()));
    end
    for (int k = 0; k < 4; k++) ra[k] = 6'($urandom);
    u_seh_host_model.spi_sel(1'b0);
    for (int k = 0; k <= 3; k++) begin
      if (k > 0) exp_rd.push_back(fdat(ra[k-1]));
      u_seh_host_model.spi_byte(k == 3 ? 8'h00 : {k == 0, ra[k], 1'b0}, k > 0);
    end
    u_seh_host_model.spi_sel(1'b1);
    @(posedge core_clk);
    rpd <= 1'b1;
    repeat (6) @(posedge core_clk);
    #1 chk_v("pd status", {6'h01, seh_pkg::SEH_MODE_NONE}, stat);
    a1 <= 1'b1;
    u_seh_host_model.idle(1'b1);
    @(posedge core_clk);
    rpd <= 1'b0;
    repeat (8) @(posedge core_clk);
    #1 chk_v("epp status", {6'h03, seh_pkg::SEH_MODE_EPP}, stat);
    a = 6'($urandom);
    d = 8'($urandom);
    u_seh_host_model.epp_cycle(1'b1, 1'b1, 1'b0, {2'b00, a});
    #1 chk_v("wait driven", 8'h00, {7'h00, a0_oe_n});
    exp_wr.push_back({a, d});
    u_seh_host_model.epp_cycle(1'b0, 1'b1, 1'b0, d);
    u_seh_host_model.epp_cycle(1'b0, 1'b1, 1'b1, ~d);
    exp_rd.push_back(fdat(a));
    u_seh_host_model.epp_cycle(1'b0, 1'b0, 1'b0, 8'h00);
    repeat (20) @(posedge core_clk);
    chk_v("queues left", 8'h00, 8'(exp_wr.size() + exp_rd.size()));
    // second hard reset: straps for the other parallel type, wait pin released again
    rpd <= 1'b1;
    repeat (6) @(posedge core_clk);
    u_seh_host_model.idle(1'b0);
    @(posedge core_clk);
    rpd <= 1'b0;
    repeat (8) @(posedge core_clk);
    #1 chk_v("par status", {6'h03, seh_pkg::SEH_MODE_PAR}, stat);
    results();
  end
endmodule // tb_top
`default_nettype wire
